/* File: hw/pmr_top.v */
// bus register access, modulator timing register and standby control
//
// Operation
// RULE_01: bits 7..5 set LED-to-evaluation delay, reset value zero.
// RULE_02: bits 4..3 pick test frequency 390.625k to 3.125M, default code 00.
// RULE_03: bits 2..0 set dead time near IR edges, reset value one.
// RULE_04: host should program timing register with one, equal to reset.
// RULE_05: host must not use the reserved ambient IR register at 90h.
// RULE_06: no measurement requested means standby, only bus stays active.
// RULE_07: in standby the IR LED sink stays off whatever current is set.
// RULE_08: a read is preceded by a write carrying only the register address.
// RULE_09: address write and read may be split by stop or repeated start.
// RULE_10: pointer advances after every byte read, for sequential registers.
// RULE_11: device answers address byte 26h for writes and 27h for reads.
// RULE_12: light result high byte at 85h, low byte at 86h.
// RULE_13: ack address and data bytes; drive data line only when needed.
`timescale 1ns/1ns
`include "pmr_defines.vh"

module pmr_top (
  input wire core_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire prox_demand,
  input wire als_demand,
  input wire led_drive_req,
  input wire [15:0] als_result,
  output reg [2:0] mod_delay,
  output reg [1:0] mod_freq_sel,
  output reg [2:0] mod_dead_time,
  output reg standby,
  output reg led_sink_en
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACK_ADDR = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_ACK_W = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_ACK_R = 7'h40;

  // seven-bit device address shared by the write and read bytes
  localparam [7:0] BUS_WR = `PMR_BUS_WR_BYTE;
  localparam [6:0] DEV_ADDR = BUS_WR[7:1];

  reg [6:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] tx_byte;
  reg [7:0] reg_ptr;
  reg is_read;
  reg first_wbyte;
  reg host_nack;
  reg [7:0] mod_timing;

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  reg scl_m;
  reg scl_s;
  reg scl_d;
  reg sda_m;
  reg sda_s;
  reg sda_d;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  // start and stop both stay valid for a repeated start [RULE_09]
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************************************
  // register read decode
  // ****************************************************************
  function [7:0] read_reg;
    input [7:0] addr;
    input [7:0] timing;
    input [15:0] result;
    begin
      case (addr)
        `PMR_REG_ALS_HI: read_reg = result[15:8]; // [RULE_12]
        `PMR_REG_ALS_LO: read_reg = result[7:0]; // [RULE_12]
        `PMR_REG_MOD_TIMING: read_reg = timing;
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // result is sampled when the byte is loaded, so a later update
  // between high and low byte can tear a 16-bit value
  wire [7:0] next_tx = read_reg(reg_ptr, mod_timing, als_result);

  // ****************************************************************
  // bus protocol engine
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      tx_byte <= 8'h00;
      reg_ptr <= 8'h00;
      is_read <= 1'b0;
      first_wbyte <= 1'b0;
      host_nack <= 1'b0;
      mod_timing <= `PMR_MOD_TIMING_RST; // [RULE_01] [RULE_02] [RULE_03]
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      // pointer survives the stop for a split address/read pair
      state <= ST_IDLE; // [RULE_09]
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_WDATA: begin
          shift_in <= {shift_in[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_ACK_R: host_nack <= sda_s;
        default: bit_cnt <= bit_cnt;
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bit_cnt == `PMR_BYTE_BITS) begin
            if (shift_in[7:1] == DEV_ADDR) begin // [RULE_11]
              state <= ST_ACK_ADDR;
              is_read <= shift_in[0];
              sda_oe <= 1'b1; // [RULE_13]
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          bit_cnt <= 4'h0;
          if (is_read) begin
            state <= ST_RDATA;
            tx_byte <= next_tx;
            sda_oe <= ~next_tx[7]; // [RULE_13]
            reg_ptr <= reg_ptr + 8'h01; // [RULE_10]
          end else begin
            state <= ST_WDATA;
            first_wbyte <= 1'b1;
            sda_oe <= 1'b0;
          end
        end
        ST_WDATA: begin
          if (bit_cnt == `PMR_BYTE_BITS) begin
            state <= ST_ACK_W;
            sda_oe <= 1'b1; // [RULE_13]
            first_wbyte <= 1'b0;
            if (first_wbyte) begin
              reg_ptr <= shift_in; // [RULE_08]
            end else begin
              if (reg_ptr == `PMR_REG_MOD_TIMING) begin
                mod_timing <= shift_in;
              end
              reg_ptr <= reg_ptr + 8'h01;
            end
          end
        end
        ST_ACK_W: begin
          state <= ST_WDATA;
          bit_cnt <= 4'h0;
          sda_oe <= 1'b0;
        end
        ST_RDATA: begin
          if (bit_cnt == 4'h7) begin
            state <= ST_ACK_R;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= ~tx_byte[6];
            tx_byte <= {tx_byte[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        ST_ACK_R: begin
          bit_cnt <= 4'h0;
          if (host_nack) begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end else begin
            // host acked: next register follows without readdressing
            state <= ST_RDATA;
            tx_byte <= next_tx;
            sda_oe <= ~next_tx[7];
            reg_ptr <= reg_ptr + 8'h01; // [RULE_10]
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // modulator fields, standby and LED sink
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mod_delay <= 3'h0;
      mod_freq_sel <= `PMR_FREQ_390K;
      mod_dead_time <= 3'h1;
      standby <= 1'b1;
      led_sink_en <= 1'b0;
    end else begin
      mod_delay <= mod_timing[`PMR_DELAY_HI:`PMR_DELAY_LO]; // [RULE_01]
      mod_freq_sel <= mod_timing[`PMR_FREQ_HI:`PMR_FREQ_LO]; // [RULE_02]
      mod_dead_time <= mod_timing[`PMR_DEAD_HI:`PMR_DEAD_LO]; // [RULE_03]
      standby <= ~(prox_demand | als_demand); // [RULE_06]
      // gated by demand, not by the current setting [RULE_07]
      led_sink_en <= led_drive_req & prox_demand;
    end
  end

endmodule // pmr_top

/* File: hw/pmr_defines.vh */
// constants for the proximity modulator configuration and bus read block
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH

// ****************************************************************
// bus addressing
// ****************************************************************
`define PMR_BUS_WR_BYTE 8'h26
`define PMR_BUS_RD_BYTE 8'h27

// ****************************************************************
// register offsets
// ****************************************************************
`define PMR_REG_ALS_HI 8'h85
`define PMR_REG_ALS_LO 8'h86
`define PMR_REG_MOD_TIMING 8'h8F
`define PMR_REG_AMBIENT_IR 8'h90

// ****************************************************************
// modulator timing fields and reset value
// ****************************************************************
`define PMR_MOD_TIMING_RST 8'h01
`define PMR_DELAY_HI 7
`define PMR_DELAY_LO 5
`define PMR_FREQ_HI 4
`define PMR_FREQ_LO 3
`define PMR_DEAD_HI 2
`define PMR_DEAD_LO 0

// frequency codes
`define PMR_FREQ_390K 2'h0
`define PMR_FREQ_781K 2'h1
`define PMR_FREQ_1M56 2'h2
`define PMR_FREQ_3M12 2'h3

// bits per byte on the bus
`define PMR_BYTE_BITS 4'h8

`endif

/* File: verif/pmr_host.sv */
// host model driving the bus clock and pulling the data wire
`timescale 1ns/1ns
module pmr_host (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  initial scl = 1'b1;
  initial pull = 1'b0;
  // data moves 80 ns after a fall so the device never sees a false stop
  task automatic bitx(input logic b, output logic r);
    pull = !b;
    #80 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
    #80;
  endtask
  // also a repeated start from a low clock
  task automatic start();
    pull = 1'b0;
    #80 scl = 1'b1;
    #80 pull = 1'b1;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic stop();
    pull = 1'b1;
    #80 scl = 1'b1;
    #80 pull = 1'b0;
    #80;
  endtask
  // a high releases the ninth slot; on reads a high is the final nack
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask
endmodule // pmr_host

/* File: verif/pmr_top_asserts.sv */
// checker for standby, led gating, reset values and data pin drive
`timescale 1ns/1ns
module pmr_chk (
  input wire core_clk,
  input wire rst,
  input wire scl_in,
  input wire prox_demand,
  input wire als_demand,
  input wire led_drive_req,
  input wire sda_out,
  input wire sda_oe,
  input wire [2:0] mod_delay,
  input wire [1:0] mod_freq_sel,
  input wire [2:0] mod_dead_time,
  input wire standby,
  input wire led_sink_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_idle;
    !prox_demand && !als_demand;
  endsequence
  sequence s_fire;
    prox_demand && led_drive_req;
  endsequence
  standby_enter_a: assert property (s_idle |=> standby)
    else $error("standby not entered");
  standby_exit_a: assert property ((prox_demand || als_demand)
    |=> !standby) else $error("standby kept");
  led_off_a: assert property (standby |-> !led_sink_en)
    else $error("led sink on in standby");
  led_follow_a: assert property (s_fire |=> led_sink_en)
    else $error("led sink missing");
  led_cause_a: assert property (!(prox_demand && led_drive_req)
    |=> !led_sink_en) else $error("led sink stray");
  sda_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin moved with clock high");
  rst_value_a: assert property ($fell(rst) |-> mod_delay == 3'h0
    && mod_freq_sel == 2'h0 && mod_dead_time == 3'h1)
    else $error("timing fields wrong after reset");
  rst_idle_a: assert property ($fell(rst) |-> standby
    && !led_sink_en && !sda_oe) else $error("outputs busy after reset");
endmodule // pmr_chk
bind pmr_top pmr_chk i_chk (.core_clk, .rst, .scl_in, .prox_demand,
  .als_demand, .led_drive_req, .sda_out, .sda_oe, .mod_delay,
  .mod_freq_sel, .mod_dead_time, .standby, .led_sink_en);

/* File: verif/tb_top.sv */
// self-checking bench for the timing register and bus read path
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 0, rst = 1, prox_demand = 0, als_demand = 0;
  logic led_drive_req = 0;
  logic [15:0] als_result = 16'h0000;
  wire scl, pull, sda_oe, sda_out, standby, led_sink_en;
  wire [2:0] mod_delay, mod_dead_time;
  wire [1:0] mod_freq_sel;
  wire sda = !(sda_oe || pull);
  int fails = 0, checked = 0, cyc = 0, seed = 2;
  logic [7:0] q, q2, v;
  logic [1:0] e;
  logic k;
  always #20 core_clk = !core_clk;
  pmr_host i_host (.scl(scl), .pull(pull), .sda(sda));
  pmr_top i_dut (.core_clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .prox_demand, .als_demand, .led_drive_req, .als_result,
    .mod_delay, .mod_freq_sel, .mod_dead_time, .standby, .led_sink_en);
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [1:0] exp_sl(input logic p, a, l);
    return {!(p || a), p && l};
  endfunction
  task automatic wr(input logic [7:0] b);
    i_host.xfer(b, 1'b1, q, k);
    chk("ack", k, 1'b0);
  endtask
  // pointer write, then stop or repeated start, then read address
  // callers never point at the reserved 90h register
  task automatic setp(input logic [7:0] a, input logic sr);
    i_host.start();
    wr(8'h26);
    wr(a);
    if (!sr) i_host.stop();
    i_host.start();
    wr(8'h27);
  endtask
  task automatic rd(output logic [7:0] d, input logic last);
    i_host.xfer(8'hFF, last, d, k);
    if (last) i_host.stop();
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst = 0;
    repeat (4) @(negedge core_clk);
    setp(8'h8F, 1'b1);
    rd(q, 1'b1);
    chk("mod_rst", q, 8'h01);
    for (int c = 0; c < 4; c++) begin
      v = 8'($random(seed));
      v[4:3] = 2'(c);
      i_host.start();
      wr(8'h26);
      wr(8'h8F);
      wr(v);
      i_host.stop();
      chk("delay", mod_delay, v[7:5]);
      chk("freq", mod_freq_sel, v[4:3]);
      chk("dead", mod_dead_time, v[2:0]);
      setp(8'h8F, c[0]);
      rd(q, 1'b1);
      chk("mod_back", q, v);
    end
    $display("test timing register done");
    // mid-run reset with a non-default timing value and live demand
    @(negedge core_clk) {prox_demand, led_drive_req} = 2'h3;
    repeat (2) @(negedge core_clk);
    rst = 1;
    @(negedge core_clk);
    chk("rmod", {mod_delay, mod_freq_sel, mod_dead_time}, 8'h01);
    chk("rst_stby", {standby, led_sink_en}, 2'h2);
    {rst, prox_demand, led_drive_req} = 3'h0;
    repeat (4) @(negedge core_clk);
    setp(8'h8F, 1'b0);
    rd(q, 1'b1);
    chk("rst_back", q, 8'h01);
    i_host.start();
    wr(8'h26);
    wr(8'h8F);
    wr(8'h01);
    i_host.stop();
    chk("dflt", {mod_delay, mod_freq_sel, mod_dead_time}, 8'h01);
    $display("test mid reset done");
    for (int n = 0; n < 3; n++) begin
      @(negedge core_clk) als_result = 16'($random(seed));
      if (n == 0) als_result = 16'hFF00;
      setp(8'h85, n[0]);
      rd(q, 1'b0);
      rd(q2, 1'b1);
      chk("als", {q, q2}, als_result);
    end
    $display("test result read done");
    i_host.start();
    i_host.xfer(8'h30, 1'b1, q, k);
    i_host.stop();
    chk("nack", k, 1'b1);
    $display("test foreign address done");
    repeat (60) begin
      @(negedge core_clk);
      {prox_demand, als_demand, led_drive_req} = 3'($random(seed));
      e = exp_sl(prox_demand, als_demand, led_drive_req);
      @(negedge core_clk);
      chk("stby_led", {standby, led_sink_en}, e);
    end
    $display("test standby done");
    results();
  end
endmodule // tb_top
